/* design/kshc_port.sv */
// host command port of the keyscan companion: two-wire slave and code registers
`include "kshc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module kshc_port #(
  parameter int FIFO_DEPTH = `KSHC_FIFO_DEPTH,
  parameter int EARLY_CYC = `KSHC_EARLY_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq_n,
  input wire logic aux_pin_zero,
  input wire logic aux_pin_one,
  input wire logic key_evt_valid,
  input wire logic [7:0] key_evt_code,
  input wire logic key_overrun,
  input wire logic halt_req,
  output logic awake,
  output logic [1:0] pin_wake_en,
  output logic [7:0] debounce_code,
  output logic [7:0] active_code
);
  kshc_pkg::kshc_state_t s_r;
  kshc_pkg::kshc_state_t s_nxt;
  logic [3:0] mem_rd_addr; // read index into the event store
  logic [7:0] mem_rd_data; // registered event from the store
  logic mem_wr; // push strobe into the store

  initial
  begin
    if (FIFO_DEPTH < 1 || FIFO_DEPTH > 15 || EARLY_CYC < 1 || EARLY_CYC > 255)
      $error("kshc_port: parameter out of range");
  end

  // opcodes the device understands, even those whose targets live elsewhere
  function automatic logic is_known(input logic [7:0] c);
    case (c)
      `KSHC_CMD_FIFO_READ, `KSHC_CMD_REREAD, `KSHC_CMD_DEBOUNCE,
      `KSHC_CMD_AUX_IN, `KSHC_CMD_AUX_OUT, `KSHC_CMD_AUX_DIR,
      `KSHC_CMD_PWM_HI, `KSHC_CMD_PWM_LO, `KSHC_CMD_PWM_CTL,
      `KSHC_CMD_INT, `KSHC_CMD_PIN_WAKE, `KSHC_CMD_STATUS,
      `KSHC_CMD_SCAN_REQ, `KSHC_CMD_ACTIVE, `KSHC_CMD_ERROR: is_known = 1'b1;
      default: is_known = 1'b0;
    endcase
  endfunction

  // index sum modulo the queue depth
  function automatic logic [3:0] wrap_add(input logic [3:0] p, input logic [4:0] k);
    logic [5:0] sum;
    sum = {2'b00, p} + {1'b0, k};
    if (sum >= 6'(FIFO_DEPTH))
      sum = sum - 6'(FIFO_DEPTH);
    wrap_add = sum[3:0];
  endfunction

  kshc_event_mem #(
    .DEPTH(16),
    .WIDTH(8)
  ) u_mem (
    .sys_clk(sys_clk),
    .wr_en(mem_wr),
    .wr_addr(s_r.wr_ptr),
    .wr_data(key_evt_code),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  // read index follows the head plus the reread offset
  assign mem_rd_addr = wrap_add(s_r.rd_ptr, s_r.peek);

  // next-state logic: line sampling, bus sequencing, code registers
  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [1:0] edge_c;
    logic [7:0] int_set;
    logic [7:0] err_set;
    logic push;
    logic pop;
    logic [7:0] txb;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    edge_c = 2'b00;
    int_set = 8'h00;
    err_set = 8'h00;
    push = 1'b0;
    pop = 1'b0;
    txb = `KSHC_EMPTY_CODE;
    s_nxt = s_r;
    // two stages on every pin; only the second and later copies are read
    s_nxt.scl.s1 = scl_i;
    s_nxt.scl.s2 = s_r.scl.s1;
    s_nxt.scl.d = s_r.scl.s2;
    s_nxt.sda.s1 = sda_i;
    s_nxt.sda.s2 = s_r.sda.s1;
    s_nxt.sda.d = s_r.sda.s2;
    s_nxt.pin_s1 = {aux_pin_one, aux_pin_zero};
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_d = s_r.pin_s2;
    scl_rise = s_r.scl.s2 & ~s_r.scl.d;
    scl_fall = ~s_r.scl.s2 & s_r.scl.d;
    // conditions are judged with clock high on both sampled copies
    start_c = s_r.scl.s2 & s_r.scl.d & s_r.sda.d & ~s_r.sda.s2;
    stop_c = s_r.scl.s2 & s_r.scl.d & ~s_r.sda.d & s_r.sda.s2;
    edge_c = (s_r.pin_s2 ^ s_r.pin_d) & s_r.pin_en;
    if (s_r.early_cnt != 8'h00)
      s_nxt.early_cnt = s_r.early_cnt - 8'h01;

    // bus sequencing; the device only ever answers the host
    if (start_c)
    begin
      // start or repeated start restarts byte framing
      if (!s_r.awake)
      begin
        s_nxt.awake = 1'b1;
        s_nxt.first_nack = 1'b1;
        s_nxt.early_cnt = 8'(EARLY_CYC);
      end
      s_nxt.phase = kshc_pkg::KSHC_RX;
      s_nxt.kind = kshc_pkg::KSHC_B_ADDR;
      s_nxt.bitcnt = 4'h0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.scl_oe = 1'b0;
      s_nxt.ack_pend = 1'b0;
    end
    else if (stop_c)
    begin
      // a finished command leaves its verdict in the status code
      if (s_r.cmd_seen)
        s_nxt.status = s_r.fail ? `KSHC_STAT_FAIL : `KSHC_STAT_OK;
      s_nxt.cmd_seen = 1'b0;
      s_nxt.phase = kshc_pkg::KSHC_IDLE;
      s_nxt.sda_oe = 1'b0;
      s_nxt.scl_oe = 1'b0;
    end
    else
    begin
      unique case (s_r.phase)
        kshc_pkg::KSHC_IDLE, kshc_pkg::KSHC_WAIT:
        begin
          s_nxt.sda_oe = 1'b0;
        end
        kshc_pkg::KSHC_RX:
        begin
          // sample on rising clock, act on the falling edge after bit eight
          if (scl_rise && s_r.bitcnt != 4'h8)
          begin
            s_nxt.shreg = {s_r.shreg[6:0], s_r.sda.s2};
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          end
          else if (scl_fall && s_r.bitcnt == 4'h8)
          begin
            s_nxt.bitcnt = 4'h0;
            s_nxt.phase = kshc_pkg::KSHC_ACK;
            s_nxt.sda_oe = 1'b1; // receiver acknowledges each byte except a foreign address or the address byte after the start that woke it from halt
            unique case (s_r.kind)
              kshc_pkg::KSHC_B_ADDR:
              begin
                s_nxt.first_nack = 1'b0;
                // start byte and foreign addresses fall out here
                if (s_r.shreg[7:1] != `KSHC_ADDR7 || s_r.first_nack)
                begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.phase = kshc_pkg::KSHC_WAIT;
                end
                s_nxt.rw = s_r.shreg[0];
              end
              kshc_pkg::KSHC_B_CMD:
              begin
                s_nxt.cmd = s_r.shreg;
                s_nxt.cmd_seen = 1'b1;
                s_nxt.peek = 5'h00;
                s_nxt.fail = 1'b0;
                if (!is_known(s_r.shreg))
                begin
                  err_set[`KSHC_ERR_BADOP] = 1'b1;
                  s_nxt.fail = 1'b1;
                end
                // opcode landing before the wake settling time ran out
                if (s_r.early_cnt != 8'h00)
                begin
                  err_set[`KSHC_ERR_EARLY] = 1'b1;
                  s_nxt.fail = 1'b1;
                end
              end
              default:
              begin
                // data bytes of write commands
                unique case (s_r.cmd)
                  `KSHC_CMD_PIN_WAKE: s_nxt.pin_en = s_r.shreg[1:0];
                  `KSHC_CMD_DEBOUNCE:
                  begin
                    if (s_r.shreg == 8'h00)
                      s_nxt.fail = 1'b1;
                    else
                      s_nxt.debounce = s_r.shreg;
                  end
                  `KSHC_CMD_ACTIVE:
                  begin
                    // active time must outlast debounce
                    if (s_r.shreg <= s_r.debounce)
                      s_nxt.fail = 1'b1;
                    else
                      s_nxt.active = s_r.shreg;
                  end
                  default: s_nxt.fail = s_r.fail;
                endcase
              end
            endcase
          end
        end
        kshc_pkg::KSHC_ACK:
        begin
          if (scl_fall)
          begin
            s_nxt.sda_oe = 1'b0;
            if (s_r.kind == kshc_pkg::KSHC_B_ADDR && s_r.rw)
            begin
              // hold the clock low while the answer byte is fetched
              s_nxt.phase = kshc_pkg::KSHC_FETCH;
              s_nxt.scl_oe = 1'b1;
              s_nxt.fetch_cnt = 2'h0;
            end
            else
            begin
              s_nxt.phase = kshc_pkg::KSHC_RX;
              s_nxt.kind = (s_r.kind == kshc_pkg::KSHC_B_ADDR) ?
                kshc_pkg::KSHC_B_CMD : kshc_pkg::KSHC_B_DATA;
            end
          end
        end
        kshc_pkg::KSHC_FETCH:
        begin
          s_nxt.fetch_cnt = s_r.fetch_cnt + 2'h1;
          // load the answer one cycle before the clock is let go
          if (s_r.fetch_cnt == 2'(`KSHC_FETCH_CYC - 1))
          begin
            unique case (s_r.cmd)
              `KSHC_CMD_INT:
              begin
                txb = s_r.int_code;
                s_nxt.int_code = 8'h00;
              end
              `KSHC_CMD_STATUS: txb = s_r.status;
              `KSHC_CMD_ERROR:
              begin
                txb = s_r.err_code;
                s_nxt.err_code = 8'h00;
              end
              `KSHC_CMD_FIFO_READ:
              begin
                // pop on each byte; empty queue answers with the empty code
                if (s_r.count != 5'h00)
                begin
                  txb = mem_rd_data;
                  pop = 1'b1;
                end
              end
              `KSHC_CMD_REREAD:
              begin
                // walk a private offset; the head stays where it was
                if (s_r.peek < s_r.count)
                begin
                  txb = mem_rd_data;
                  s_nxt.peek = s_r.peek + 5'h01;
                end
              end
              default: txb = 8'h00;
            endcase
            s_nxt.shreg = {txb[6:0], 1'b0};
            s_nxt.sda_oe = ~txb[7];
            s_nxt.bitcnt = 4'h1;
          end
          else if (s_r.fetch_cnt == 2'(`KSHC_FETCH_CYC))
          begin
            // data settled a cycle ago, so it never moves with the clock high
            s_nxt.scl_oe = 1'b0;
            s_nxt.phase = kshc_pkg::KSHC_TX;
          end
        end
        kshc_pkg::KSHC_TX:
        begin
          if (scl_fall)
          begin
            if (s_r.bitcnt == 4'h8)
            begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.phase = kshc_pkg::KSHC_HACK;
            end
            else
            begin
              s_nxt.sda_oe = ~s_r.shreg[7];
              s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
              s_nxt.bitcnt = s_r.bitcnt + 4'h1;
            end
          end
        end
        kshc_pkg::KSHC_HACK:
        begin
          // host nack ends the read; ack asks for one more byte
          if (scl_rise)
          begin
            if (s_r.sda.s2)
              s_nxt.phase = kshc_pkg::KSHC_WAIT;
            else
              s_nxt.ack_pend = 1'b1;
          end
          else if (scl_fall && s_r.ack_pend)
          begin
            s_nxt.ack_pend = 1'b0;
            s_nxt.phase = kshc_pkg::KSHC_FETCH;
            s_nxt.scl_oe = 1'b1;
            s_nxt.fetch_cnt = 2'h0;
          end
        end
        default:
        begin
          s_nxt.phase = kshc_pkg::KSHC_IDLE;
          s_nxt.sda_oe = 1'b0;
          s_nxt.scl_oe = 1'b0;
        end
      endcase
    end

    // key events enter the queue while there is room
    if (key_evt_valid)
    begin
      if (s_r.count < 5'(FIFO_DEPTH))
      begin
        push = 1'b1;
        int_set[`KSHC_INT_KEY] = 1'b1;
      end
      else
        err_set[`KSHC_ERR_QFULL] = 1'b1;
    end
    if (key_overrun)
      err_set[`KSHC_ERR_KEYS] = 1'b1;
    // pin edges: one pin enabled marks both bits
    if (edge_c != 2'b00)
    begin
      if (s_r.pin_en == 2'b11)
      begin
        int_set[`KSHC_INT_PIN0] = edge_c[0];
        int_set[`KSHC_INT_PIN1] = edge_c[1];
      end
      else
      begin
        int_set[`KSHC_INT_PIN0] = 1'b1;
        int_set[`KSHC_INT_PIN1] = 1'b1;
      end
      if (!s_r.awake)
      begin
        s_nxt.awake = 1'b1;
        s_nxt.status = `KSHC_STAT_WAKE;
      end
    end
    // a pending cause hit again is folded in before the host saw it
    if ((int_set & s_r.int_code) != 8'h00)
      err_set[`KSHC_ERR_LOST] = 1'b1;
    if (err_set != 8'h00)
      int_set[`KSHC_INT_ERR] = 1'b1;
    // sets are merged after any clear-on-read so a same-cycle event survives
    s_nxt.int_code = s_nxt.int_code | (int_set & 8'h0f);
    s_nxt.err_code = s_nxt.err_code | (err_set & 8'h57);
    s_nxt.irq_n = (s_nxt.int_code == 8'h00);

    // queue bookkeeping
    if (push)
      s_nxt.wr_ptr = wrap_add(s_r.wr_ptr, 5'h01);
    if (pop)
      s_nxt.rd_ptr = wrap_add(s_r.rd_ptr, 5'h01);
    s_nxt.count = s_r.count + {4'h0, push} - {4'h0, pop};

    // halt only between transfers, so a frame is never cut short
    if (halt_req && s_r.phase == kshc_pkg::KSHC_IDLE && !start_c)
      s_nxt.awake = 1'b0;
  end

  assign mem_wr = key_evt_valid && (s_r.count < 5'(FIFO_DEPTH));

  // state register with synchronous reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
      s_r.scl <= 3'b111;
      s_r.sda <= 3'b111;
      s_r.phase <= kshc_pkg::KSHC_IDLE;
      s_r.awake <= 1'b1;
      s_r.status <= `KSHC_STAT_RESET;
      s_r.debounce <= 8'(`KSHC_DEBOUNCE_DEF);
      s_r.active <= 8'(`KSHC_ACTIVE_DEF);
      s_r.irq_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from the state register
  assign scl_o = s_r.drive_lvl;
  assign scl_oe = s_r.scl_oe;
  assign sda_o = s_r.drive_lvl;
  assign sda_oe = s_r.sda_oe;
  assign irq_n = s_r.irq_n;
  assign awake = s_r.awake;
  assign pin_wake_en = s_r.pin_en;
  assign debounce_code = s_r.debounce;
  assign active_code = s_r.active;
endmodule
`default_nettype wire

/* pkg/kshc_consts.svh */
// constants of the keyscan host command port: codes, bit positions, timing
`ifndef KSHC_CONSTS_SVH
`define KSHC_CONSTS_SVH
`define KSHC_ADDR7 7'h51
`define KSHC_CMD_FIFO_READ 8'h20
`define KSHC_CMD_REREAD 8'h21
`define KSHC_CMD_DEBOUNCE 8'h22
`define KSHC_CMD_AUX_IN 8'h30
`define KSHC_CMD_AUX_OUT 8'h31
`define KSHC_CMD_AUX_DIR 8'h32
`define KSHC_CMD_PWM_HI 8'h40
`define KSHC_CMD_PWM_LO 8'h41
`define KSHC_CMD_PWM_CTL 8'h42
`define KSHC_CMD_INT 8'hd0
`define KSHC_CMD_PIN_WAKE 8'hd1
`define KSHC_CMD_STATUS 8'he0
`define KSHC_CMD_SCAN_REQ 8'he3
`define KSHC_CMD_ACTIVE 8'he4
`define KSHC_CMD_ERROR 8'hf0
`define KSHC_INT_ERR 3
`define KSHC_INT_PIN1 2
`define KSHC_INT_PIN0 1
`define KSHC_INT_KEY 0
`define KSHC_ERR_QFULL 6
`define KSHC_ERR_LOST 4
`define KSHC_ERR_KEYS 2
`define KSHC_ERR_BADOP 1
`define KSHC_ERR_EARLY 0
`define KSHC_STAT_RESET 8'h00
`define KSHC_STAT_WAKE 8'h02
`define KSHC_STAT_OK 8'h06
`define KSHC_STAT_FAIL 8'h15
`define KSHC_FIFO_DEPTH 14
`define KSHC_EMPTY_CODE 8'h00
`define KSHC_CLK_MHZ 50
`define KSHC_EARLY_NS 2000
`define KSHC_EARLY_CYC ((`KSHC_EARLY_NS * `KSHC_CLK_MHZ + 999) / 1000)
`define KSHC_STEP_MS 4
`define KSHC_DEBOUNCE_MS 10
`define KSHC_ACTIVE_MS 500
`define KSHC_DEBOUNCE_DEF ((`KSHC_DEBOUNCE_MS + `KSHC_STEP_MS - 1) / `KSHC_STEP_MS)
`define KSHC_ACTIVE_DEF ((`KSHC_ACTIVE_MS + `KSHC_STEP_MS - 1) / `KSHC_STEP_MS)
`define KSHC_FETCH_CYC 2
`endif

/* pkg/kshc_pkg.sv */
// types of the keyscan host command port
package kshc_pkg;
  typedef enum logic [2:0] {
    KSHC_IDLE = 3'h0,
    KSHC_RX = 3'h1,
    KSHC_ACK = 3'h2,
    KSHC_TX = 3'h3,
    KSHC_HACK = 3'h4,
    KSHC_FETCH = 3'h5,
    KSHC_WAIT = 3'h6
  } kshc_phase_t;
  typedef enum logic [1:0] {
    KSHC_B_ADDR = 2'h0,
    KSHC_B_CMD = 2'h1,
    KSHC_B_DATA = 2'h2
  } kshc_kind_t;
  // one sampled two-wire line: two sync stages plus a delayed copy
  typedef struct packed {
    logic s1;
    logic s2;
    logic d;
  } kshc_sync_t;
  typedef struct packed {
    kshc_sync_t scl;
    kshc_sync_t sda;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_d;
    kshc_phase_t phase;
    kshc_kind_t kind;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [7:0] cmd;
    logic cmd_seen;
    logic fail;
    logic ack_pend;
    logic awake;
    logic first_nack;
    logic [7:0] early_cnt;
    logic [7:0] int_code;
    logic [7:0] err_code;
    logic [7:0] status;
    logic [1:0] pin_en;
    logic [7:0] debounce;
    logic [7:0] active;
    logic [3:0] rd_ptr;
    logic [3:0] wr_ptr;
    logic [4:0] count;
    logic [4:0] peek;
    logic [1:0] fetch_cnt;
    logic sda_oe;
    logic scl_oe;
    logic drive_lvl;
    logic irq_n;
  } kshc_state_t;
endpackage

/* design/kshc_event_mem.sv */
// small key event store with registered read data
`timescale 1ns/1ns
`default_nettype none
module kshc_event_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output var logic [WIDTH-1:0] rd_data
);
  // no reset on the array: contents are only read behind the fill count
  logic [WIDTH-1:0] mem [DEPTH];

  initial
  begin
    if (DEPTH < 2 || WIDTH < 1)
      $error("kshc_event_mem: bad geometry");
  end

  // write port and registered read port
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

/* bench/kshc_port_properties.sv */
// pin-level assertions for the keyscan host command port
`timescale 1ns/1ns
`default_nettype none
module kshc_port_properties #(
  parameter int FIFO_DEPTH = 14,
  parameter int EARLY_CYC = 100
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic irq_n,
  input wire logic aux_pin_zero,
  input wire logic key_evt_valid,
  input wire logic halt_req,
  input wire logic awake,
  input wire logic [1:0] pin_wake_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // reset leaves both wires released and the request idle
  a_reset_idle: assert property (disable iff (1'b0)
    sys_rst |=> !sda_oe && !scl_oe && irq_n && awake) else $error("reset state wrong");
  // open drain: only ever pulls low
  a_open_drain: assert property (!scl_o && !sda_o) else $error("pin driven high");
  // stretch only a clock the host already pulled low
  a_stretch_low: assert property ($rose(scl_oe) |-> !$past(scl_i))
    else $error("stretch on high clock");
  a_stretch_len: assert property ($rose(scl_oe) |-> scl_oe[*3] ##1 !scl_oe)
    else $error("stretch length wrong");
  // halted device stays off the bus
  a_halt_quiet: assert property (!awake |-> !sda_oe && !scl_oe)
    else $error("bus driven in halt");
  a_halt_cause: assert property ($fell(awake) |-> $past(halt_req))
    else $error("halt without request");
  a_key_irq: assert property (key_evt_valid |=> !irq_n)
    else $error("key event gave no request");
  // pin is synchronised, so allow a few cycles
  a_pin_irq: assert property ($changed(aux_pin_zero) && pin_wake_en[0] |-> ##[1:8] !irq_n)
    else $error("pin edge gave no request");
  // data may only move while the clock is low
  a_sda_in_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data moved with clock high");
  cover property ($rose(scl_oe));
  cover property ($fell(awake));
  cover property ($fell(irq_n));
endmodule
bind kshc_port kshc_port_properties #(.FIFO_DEPTH(FIFO_DEPTH), .EARLY_CYC(EARLY_CYC)) u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_o(sda_o), .sda_oe(sda_oe), .irq_n(irq_n), .aux_pin_zero(aux_pin_zero),
  .key_evt_valid(key_evt_valid), .halt_req(halt_req), .awake(awake),
  .pin_wake_en(pin_wake_en));
`default_nettype wire

/* bench/kshc_host_model.sv */
// host-side two-wire master model, open drain, 160 ns bit time
`timescale 1ns/1ns
`default_nettype none
module kshc_host_model (
  output var logic scl_h,
  output var logic sda_h,
  input wire logic scl,
  input wire logic sda
);
  // released lines float high through the pull-up
  initial
  begin
    scl_h = 1'b1;
    sda_h = 1'b1;
  end
  // one bit: low 100 ns, high 60 ns; a stretched clock is waited out
  task automatic bitx(input logic b, output logic r);
    int n;
    n = 0;
    #20 sda_h = b;
    #80 scl_h = 1'b1;
    while (scl !== 1'b1 && n < 200)
    begin
      #10 n++;
    end
    #30 r = sda;
    #30 scl_h = 1'b0;
  endtask
  // start or repeated start from any bus state
  task automatic start();
    #20 sda_h = 1'b1;
    #80 scl_h = 1'b1;
    #80 sda_h = 1'b0;
    #80 scl_h = 1'b0;
  endtask
  task automatic stop();
    #20 sda_h = 1'b0;
    #80 scl_h = 1'b1;
    #80 sda_h = 1'b1;
    #80;
  endtask
  // msb first, then the ack slot with data released
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(d[i], r);
    end
    bitx(1'b1, ack);
  endtask
  // nack on the final byte ends the read
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, d[i]);
    end
    bitx(last, r);
  endtask
endmodule
`default_nettype wire

/* bench/test_kshc_port.sv */
// self-checking bench of the keyscan host command port
`timescale 1ns/1ns
`default_nettype none
module test_kshc_port;
  logic sys_clk, sys_rst, aux_pin_zero, aux_pin_one, key_evt_valid, key_overrun, halt_req;
  logic scl_o, scl_oe, sda_o, sda_oe, irq_n, awake, scl_h, sda_h;
  logic [7:0] key_evt_code, debounce_code, active_code;
  logic [1:0] pin_wake_en;
  logic [7:0] b [0:15];
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // wired-and of both parties
  wire scl = scl_h & ~scl_oe;
  wire sda = sda_h & ~sda_oe;
  // short early window keeps the run brief
  kshc_port #(.FIFO_DEPTH(14), .EARLY_CYC(20)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .irq_n(irq_n), .aux_pin_zero(aux_pin_zero), .aux_pin_one(aux_pin_one),
    .key_evt_valid(key_evt_valid), .key_evt_code(key_evt_code), .key_overrun(key_overrun),
    .halt_req(halt_req), .awake(awake), .pin_wake_en(pin_wake_en),
    .debounce_code(debounce_code), .active_code(active_code));
  kshc_host_model host (.scl_h(scl_h), .sda_h(sda_h), .scl(scl), .sda(sda));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      $display("ERROR at %0t: timeout", $time);
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic key(input logic [7:0] c);
    tick(1);
    key_evt_code = c;
    key_evt_valid = 1'b1;
    tick(1);
    key_evt_valid = 1'b0;
    tick(2);
  endtask
  task automatic halt();
    tick(1);
    halt_req = 1'b1;
    tick(1);
    halt_req = 1'b0;
    tick(3);
  endtask
  // read command: address, command, restart, read address, n bytes
  task automatic rd(input logic [7:0] cmd, input int n);
    logic a;
    host.start();
    host.wbyte(8'ha2, a);
    chk({7'h0, a}, 8'h00);
    host.wbyte(cmd, a);
    chk({7'h0, a}, 8'h00);
    host.start();
    host.wbyte(8'ha3, a);
    chk({7'h0, a}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      host.rbyte(i == n - 1, b[i]);
    end
    host.stop();
    tick(20);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    logic a;
    host.start();
    host.wbyte(8'ha2, a);
    host.wbyte(cmd, a);
    chk({7'h0, a}, 8'h00);
    host.wbyte(d, a);
    chk({7'h0, a}, 8'h00);
    host.stop();
    tick(20);
  endtask
  task automatic t_reset();
    chk({7'h0, irq_n}, 8'h01);
    chk(debounce_code, 8'h03);
    chk(active_code, 8'h7d);
    rd(8'he0, 1);
    chk(b[0], 8'h00);
    $display("test reset done");
  endtask
  task automatic t_keys();
    key(8'h85);
    chk({7'h0, irq_n}, 8'h00);
    rd(8'hd0, 1);
    chk(b[0], 8'h01);
    chk({7'h0, irq_n}, 8'h01);
    key(8'h05);
    rd(8'hd0, 1);
    rd(8'h21, 2);
    chk(b[1], 8'h05);
    rd(8'h21, 1);
    chk(b[0], 8'h85);
    rd(8'h20, 3);
    chk(b[0], 8'h85);
    chk(b[1], 8'h05);
    chk(b[2], 8'h00);
    $display("test keys done");
  endtask
  task automatic t_pins();
    wr(8'hd1, 8'h01);
    chk({6'h0, pin_wake_en}, 8'h01);
    aux_pin_zero = 1'b1;
    tick(10);
    chk({7'h0, irq_n}, 8'h00);
    rd(8'hd0, 1);
    chk(b[0], 8'h06);
    wr(8'hd1, 8'h03);
    aux_pin_one = 1'b1;
    tick(10);
    rd(8'hd0, 1);
    chk(b[0], 8'h04);
    $display("test pins done");
  endtask
  task automatic t_wake();
    logic a;
    halt();
    chk({7'h0, awake}, 8'h00);
    host.start();
    host.wbyte(8'ha2, a);
    chk({7'h0, a}, 8'h01);
    host.stop();
    chk({7'h0, awake}, 8'h01);
    #2000;
    rd(8'he0, 1);
    chk(b[0], 8'h06);
    halt();
    host.start();
    host.wbyte(8'h01, a);
    chk({7'h0, a}, 8'h01);
    host.stop();
    #2000;
    rd(8'he0, 1);
    halt();
    aux_pin_zero = 1'b0;
    tick(30);
    chk({7'h0, awake}, 8'h01);
    rd(8'he0, 1);
    chk(b[0], 8'h02);
    rd(8'hd0, 1);
    chk(b[0], 8'h02);
    $display("test wake done");
  endtask
  task automatic t_bad();
    logic a;
    host.start();
    host.wbyte(8'ha2, a);
    host.wbyte(8'h55, a);
    host.stop();
    tick(20);
    rd(8'he0, 1);
    chk(b[0], 8'h15);
    rd(8'hd0, 1);
    chk(b[0], 8'h08);
    rd(8'hf0, 2);
    chk(b[0], 8'h02);
    chk(b[1], 8'h00);
    rd(8'he0, 1);
    chk(b[0], 8'h06);
    tick(1);
    key_overrun = 1'b1;
    tick(1);
    key_overrun = 1'b0;
    tick(3);
    rd(8'hd0, 1);
    chk(b[0], 8'h08);
    rd(8'hf0, 1);
    chk(b[0], 8'h04);
    wr(8'h22, 8'h05);
    chk(debounce_code, 8'h05);
    wr(8'he4, 8'h05);
    chk(active_code, 8'h7d);
    rd(8'he0, 1);
    chk(b[0], 8'h15);
    $display("test errors done");
  endtask
  // one event past capacity is dropped and flagged
  task automatic t_full();
    for (int i = 1; i <= 15; i++)
    begin
      key(8'h80 | i[7:0]);
    end
    rd(8'hf0, 1);
    chk(b[0] & 8'h40, 8'h40);
    rd(8'hd0, 1);
    rd(8'h20, 15);
    for (int i = 0; i < 14; i++)
    begin
      chk(b[i], 8'h81 + i[7:0]);
    end
    chk(b[14], 8'h00);
    $display("test full done");
  endtask
  initial
  begin
    sys_rst = 1'b1;
    aux_pin_zero = 1'b0;
    aux_pin_one = 1'b0;
    key_evt_valid = 1'b0;
    key_evt_code = 8'h00;
    key_overrun = 1'b0;
    halt_req = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    tick(5);
    t_reset();
    t_keys();
    t_pins();
    t_wake();
    t_bad();
    t_full();
    wrap_up();
  end
endmodule
`default_nettype wire
